/* modem_partner.sv */
`timescale 1ns/1ps

module modem_partner (
	input wire logic frame_on,
	input wire logic cts_req,
	input wire logic cd_req,
	input wire logic bus_mode,
	input wire logic bus_jam,
	input wire logic txd_out,
	input wire logic txd_oe,
	output logic tx_clock_pin,
	output logic cts_pin,
	output logic crystal_clock_input,
	output logic cd_pin
);
	// ********
	// Clocks: link clock stands still outside frames, crystal runs free
	// ********
	initial begin
		tx_clock_pin = 1'b0;
		crystal_clock_input = 1'b0;
	end
	always #40 if (frame_on) tx_clock_pin = ~tx_clock_pin;
	always #31 crystal_clock_input = ~crystal_clock_input;

	// Shared bus has a pull-up; an enabled driver sending zero or a jam pulls it low
	// Request-to-send is never looked at here
	assign cts_pin = bus_mode ? !(bus_jam || (txd_oe && !txd_out)) : !cts_req;
	assign cd_pin = cd_req;
endmodule : modem_partner

/* modem_pins_asserts.sv */
`timescale 1ns/1ps

module modem_pins_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_active,
	input wire logic txd_out,
	input wire logic txd_oe,
	input wire logic rx_strobe,
	input wire logic frame_sync,
	input wire logic modem_cd_level,
	input wire logic tx_clock_gate_input,
	input wire logic rx_clock_gate_input,
	input wire logic collision_pulse,
	input wire logic cts_change_pulse,
	input wire logic cd_change_pulse,
	input wire logic use_crystal
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ********
	// Register port handshake
	// ********
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
	a_slverr_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");

	// ********
	// Pin function selection, exclusive per clock mode
	// ********
	a_strobe_mode_only: assert property (rx_strobe |-> !frame_sync && !rx_clock_gate_input)
		else $error("strobe shares mode");
	a_gate_mode_only: assert property (tx_clock_gate_input |-> !rx_strobe && !frame_sync
		&& !modem_cd_level) else $error("gate shares mode");
	// Crystal use changes only right after a register write
	a_crystal_static: assert property ($changed(use_crystal) |-> $past(pready)
		|| $past(pready, 2)) else $error("crystal select moved");

	// ********
	// Events and transmit data
	// ********
	// Filter needs two agreeing stages, so pulses never merge
	a_cts_event_pulse: assert property (cts_change_pulse |=> !cts_change_pulse)
		else $error("cts event long");
	a_cd_event_pulse: assert property (cd_change_pulse |=> !cd_change_pulse)
		else $error("cd event long");
	a_open_drain_one: assert property (!txd_oe |-> txd_out) else $error("released on zero");
	a_collision_cause: assert property (collision_pulse |-> $past(tx_active))
		else $error("collision idle");

	c_collision: cover property (collision_pulse);
	c_cts_event: cover property (cts_change_pulse);
	c_frame_sync: cover property (frame_sync);
endmodule : modem_pins_asserts

bind serial_modem_control_pins modem_pins_asserts modem_pins_asserts_inst (
	.ref_clk(ref_clk), .rst(rst), .pready(pready), .pslverr(pslverr), .tx_active(tx_active),
	.txd_out(txd_out), .txd_oe(txd_oe), .rx_strobe(rx_strobe), .frame_sync(frame_sync),
	.modem_cd_level(modem_cd_level), .tx_clock_gate_input(tx_clock_gate_input),
	.rx_clock_gate_input(rx_clock_gate_input), .collision_pulse(collision_pulse),
	.cts_change_pulse(cts_change_pulse), .cd_change_pulse(cd_change_pulse),
	.use_crystal(use_crystal));

/* modem_pins_pkg.sv */
package modem_pins_pkg;

	// ********************************************
	// Register map (APB byte addresses)
	// ********************************************
	localparam logic [7:0] CHANNEL_CONFIG_REG_ONE_OFS = 8'h00;
	localparam logic [7:0] PIN_STATUS_OFS = 8'h04;

	// ********************************************
	// Configuration field positions
	// ********************************************
	localparam int CFG_RTS_REQUEST_POS = 0;
	localparam int CFG_BUS_RTS_POS = 1; // Two bits
	localparam int CFG_ASYNC_RTS_POS = 3; // Two bits
	localparam int CFG_TX_CLOCK_OUTPUT_ENABLE_POS = 5;
	localparam int CFG_OPEN_DRAIN_POS = 6;
	localparam int CFG_BUS_CONFIG_POS = 7;
	localparam int CFG_ASYNC_MODE_POS = 8;
	localparam int CFG_CLOCK_MODE_POS = 9; // Three bits
	localparam int CFG_MODE_B_POS = 12;
	localparam int CFG_AUTO_START_POS = 13;
	localparam int CFG_CTS_EVENT_EN_POS = 14;
	localparam int CFG_CD_EVENT_EN_POS = 15;
	localparam logic [31:0] CFG_WRITE_MASK = 32'h0000ffff;
	localparam logic [31:0] CFG_RESET = 32'h00000000;

	// ********************************************
	// Status field positions
	// ********************************************
	localparam int STAT_CTS_LEVEL_POS = 0;
	localparam int STAT_CD_LEVEL_POS = 1;
	localparam int STAT_COLLISION_POS = 2;
	localparam int STAT_CTS_CHANGE_POS = 3;
	localparam int STAT_CD_CHANGE_POS = 4;
	localparam int STAT_RTS_PIN_POS = 5;
	localparam int STAT_TX_ENABLE_POS = 6;
	localparam logic [2:0] STAT_STICKY_RESET = 3'h0;

	// ********************************************
	// Mode encodings
	// ********************************************
	localparam logic [1:0] BUS_RTS_ON_TX = 2'h0;
	localparam logic [1:0] BUS_RTS_ON_RX = 2'h1;
	localparam logic [1:0] ASYNC_RTS_AUTO = 2'h0;
	localparam logic [1:0] ASYNC_RTS_FLOW = 2'h1;
	localparam logic [1:0] ASYNC_RTS_HOST = 2'h2;
	localparam logic [2:0] CLK_MODE_0 = 3'h0;
	localparam logic [2:0] CLK_MODE_1 = 3'h1;
	localparam logic [2:0] CLK_MODE_4 = 3'h4;
	localparam logic [2:0] CLK_MODE_5 = 3'h5;
	localparam logic [2:0] CLK_MODE_6 = 3'h6;
	localparam logic [2:0] CLK_MODE_7 = 3'h7;

	// Request hold sequence for software-driven request-to-send
	typedef enum logic [2:0] {
		RTS_IDLE = 3'h1,
		RTS_ON = 3'h2,
		RTS_DRAIN = 3'h4
	} rts_state_e;

	// Three-stage synchroniser with agreement filter
	typedef struct packed {
		logic [2:0] ff;
		logic filt;
	} sync_s;

	// Clear-to-send idles high, so its chain starts there and no false enable follows reset
	localparam sync_s CTS_SYNC_RESET = '{ff: 3'h7, filt: 1'b1};

endpackage : modem_pins_pkg

/* serial_modem_control_pins.sv */
// Functional notes
// - Setting the request bit drives request-to-send low.
// - After clearing, output returns high only when transmitter finished, nothing pending.
// - Bus option: request-to-send low during transmission, one clock late, not on collisions.
// - Bus options: low during frame reception, or always high (disabled).
// - Async default: active from transmission start until transmission completes.
// - Async flow: active when shadow receive part empty, inactive at threshold.
// - Async option: host software controls request-to-send directly.
// - Clock mode 4 with enable: transmit clock drives the shared pin, aligned to data.
// - Outside clock mode 4 and bus configuration, transmitter enabled only while clear-to-send input is low.
// - Optional event on any clear-to-send level change.
// - Bus mode: collision when driving one but collision input reads zero.
// - Clock mode 4: shared pins become transmit and receive clock gates.
// - Clock modes 0,2,3,6,7: carrier detect is a readable modem input.
// - Auto-start: carrier detect acts as receiver enable.
// - Clock mode 1: carrier detect is a receive strobe.
// - Optional event on any carrier detect level change.
// - Clock mode 5: carrier detect pin is the frame sync input.
// - Crystal is common clock; oscillator used in modes 0b, 6, 7.
// - Transmit data output selectable push-pull or open-drain.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module serial_modem_control_pins (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_clock_pin,
	input wire logic cts_pin,
	input wire logic cd_pin,
	input wire logic crystal_clock_input,
	output logic rts_pin,
	output logic txd_out,
	output logic txd_oe,
	input wire logic tx_data_in,
	input wire logic tx_active,
	input wire logic tx_pending,
	input wire logic tx_collision_bit,
	input wire logic rx_frame_active,
	input wire logic shadow_empty,
	input wire logic fifo_threshold,
	output logic tx_enable,
	output logic rx_enable,
	output logic rx_strobe,
	output logic frame_sync,
	output logic tx_clock_gate_input,
	output logic rx_clock_gate_input,
	output logic modem_cd_level,
	output logic collision_pulse,
	output logic cts_change_pulse,
	output logic cd_change_pulse,
	output logic use_crystal,
	output logic crystal_clock_level
);

	// ********************************************
	// State
	// ********************************************
	typedef struct packed {
		logic [31:0] cfg;
		logic [2:0] sticky;
		modem_pins_pkg::sync_s cts_sync;
		modem_pins_pkg::sync_s cd_sync;
		modem_pins_pkg::sync_s txc_sync;
		modem_pins_pkg::sync_s xtal_sync;
		logic txc_prev;
		logic tx_delayed;
		logic flow_active;
		modem_pins_pkg::rts_state_e rts_state;
		logic [3:0] txd_hist;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rts_pin;
		logic txd_out;
		logic txd_oe;
		logic tx_enable;
		logic rx_enable;
		logic rx_strobe;
		logic frame_sync;
		logic tx_gate;
		logic rx_gate;
		logic modem_cd;
		logic collision;
		logic cts_change;
		logic cd_change;
		logic use_crystal;
		logic crystal_level;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// Shift pin into chain; the filtered level only moves once stages two and three agree
	function automatic modem_pins_pkg::sync_s sync_step(input modem_pins_pkg::sync_s cur,
		input logic pin);
		modem_pins_pkg::sync_s nxt;
		nxt.ff = {cur.ff[1:0], pin};
		nxt.filt = (cur.ff[1] == cur.ff[2]) ? cur.ff[2] : cur.filt;
		return nxt;
	endfunction : sync_step

	// ********************************************
	// Decoded configuration
	// ********************************************
	logic rts_request;
	logic [1:0] bus_rts_mode;
	logic [1:0] async_rts_mode;
	logic tx_clock_output_enable;
	logic open_drain;
	logic bus_config;
	logic async_mode;
	logic [2:0] clock_mode;
	logic mode_b;
	logic auto_start;
	logic cts_event_en;
	logic cd_event_en;

	// Mode fields are treated as static while the channel runs
	assign rts_request = state_reg.cfg[modem_pins_pkg::CFG_RTS_REQUEST_POS];
	assign bus_rts_mode = state_reg.cfg[modem_pins_pkg::CFG_BUS_RTS_POS +: 2];
	assign async_rts_mode = state_reg.cfg[modem_pins_pkg::CFG_ASYNC_RTS_POS +: 2];
	assign tx_clock_output_enable = state_reg.cfg[modem_pins_pkg::CFG_TX_CLOCK_OUTPUT_ENABLE_POS];
	assign open_drain = state_reg.cfg[modem_pins_pkg::CFG_OPEN_DRAIN_POS];
	assign bus_config = state_reg.cfg[modem_pins_pkg::CFG_BUS_CONFIG_POS];
	assign async_mode = state_reg.cfg[modem_pins_pkg::CFG_ASYNC_MODE_POS];
	assign clock_mode = state_reg.cfg[modem_pins_pkg::CFG_CLOCK_MODE_POS +: 3];
	assign mode_b = state_reg.cfg[modem_pins_pkg::CFG_MODE_B_POS];
	assign auto_start = state_reg.cfg[modem_pins_pkg::CFG_AUTO_START_POS];
	assign cts_event_en = state_reg.cfg[modem_pins_pkg::CFG_CTS_EVENT_EN_POS];
	assign cd_event_en = state_reg.cfg[modem_pins_pkg::CFG_CD_EVENT_EN_POS];

	// ********************************************
	// Next-state logic
	// ********************************************
	always_comb begin
		logic setup;
		logic access;
		logic wr;
		logic hit_cfg;
		logic hit_stat;
		logic cts_lvl;
		logic cd_lvl;
		logic txc_rise;
		logic rts_active;
		logic coll_now;
		logic cts_edge;
		logic cd_edge;
		logic mode4;
		logic [2:0] set_bits;
		logic [2:0] clr_bits;
		setup = 1'b0;
		access = 1'b0;
		wr = 1'b0;
		hit_cfg = 1'b0;
		hit_stat = 1'b0;
		cts_lvl = 1'b0;
		cd_lvl = 1'b0;
		txc_rise = 1'b0;
		rts_active = 1'b0;
		coll_now = 1'b0;
		cts_edge = 1'b0;
		cd_edge = 1'b0;
		mode4 = 1'b0;
		set_bits = 3'h0;
		clr_bits = 3'h0;
		state_next = state_reg;

		// Input synchronisers; only filtered levels are used below
		state_next.cts_sync = sync_step(state_reg.cts_sync, cts_pin);
		state_next.cd_sync = sync_step(state_reg.cd_sync, cd_pin);
		state_next.txc_sync = sync_step(state_reg.txc_sync, tx_clock_pin);
		state_next.xtal_sync = sync_step(state_reg.xtal_sync, crystal_clock_input);
		cts_lvl = state_reg.cts_sync.filt;
		cd_lvl = state_reg.cd_sync.filt;
		mode4 = (clock_mode == modem_pins_pkg::CLK_MODE_4);

		// Edge finder on the sampled transmit clock
		state_next.txc_prev = state_reg.txc_sync.filt;
		txc_rise = state_reg.txc_sync.filt & ~state_reg.txc_prev;

		// Frame activity held back one transmit clock period for the bus option
		if (txc_rise) begin
			state_next.tx_delayed = tx_active;
		end

		// Software request with hold until the transmitter has drained
		unique case (state_reg.rts_state)
			modem_pins_pkg::RTS_IDLE: begin
				if (rts_request) begin
					state_next.rts_state = modem_pins_pkg::RTS_ON;
				end
			end
			modem_pins_pkg::RTS_ON: begin
				if (!rts_request) begin
					state_next.rts_state = modem_pins_pkg::RTS_DRAIN;
				end
			end
			modem_pins_pkg::RTS_DRAIN: begin
				if (rts_request) begin
					state_next.rts_state = modem_pins_pkg::RTS_ON;
				end else if (!tx_active && !tx_pending) begin
					state_next.rts_state = modem_pins_pkg::RTS_IDLE;
				end
			end
			default: begin
				state_next.rts_state = modem_pins_pkg::RTS_IDLE;
			end
		endcase

		// Flow control: set on empty shadow part, cleared at threshold
		if (fifo_threshold) begin
			state_next.flow_active = 1'b0;
		end else if (shadow_empty) begin
			state_next.flow_active = 1'b1;
		end

		// Request-to-send source selection
		if (bus_config) begin
			if (bus_rts_mode == modem_pins_pkg::BUS_RTS_ON_TX) begin
				rts_active = state_reg.tx_delayed & ~tx_collision_bit;
			end else if (bus_rts_mode == modem_pins_pkg::BUS_RTS_ON_RX) begin
				rts_active = rx_frame_active;
			end else begin
				rts_active = 1'b0;
			end
		end else if (async_mode) begin
			if (async_rts_mode == modem_pins_pkg::ASYNC_RTS_FLOW) begin
				rts_active = state_reg.flow_active;
			end else if (async_rts_mode == modem_pins_pkg::ASYNC_RTS_HOST) begin
				rts_active = rts_request;
			end else begin
				rts_active = tx_active;
			end
		end else begin
			rts_active = rts_request | (state_reg.rts_state != modem_pins_pkg::RTS_IDLE);
		end

		// Shared pin carries the transmit clock in mode 4 with clock output enabled, else active-low request.
		// Always driven push-pull, even where the partner should ignore it.
		if (mode4 && tx_clock_output_enable) begin
			state_next.rts_pin = state_reg.txc_sync.filt;
		end else begin
			state_next.rts_pin = ~rts_active;
		end

		// Transmit data: open-drain only enables the driver for a zero
		state_next.txd_out = tx_data_in;
		state_next.txd_oe = open_drain ? ~tx_data_in : 1'b1;

		// Sent data aged four cycles, three stages plus filter, so a rising one never flags early
		state_next.txd_hist = {state_reg.txd_hist[2:0], state_reg.txd_out};
		coll_now = bus_config & tx_active & state_reg.txd_hist[3] & ~cts_lvl;
		state_next.collision = coll_now;

		// Shared clear-to-send pin: gate in mode 4, collision input on the bus
		if (mode4) begin
			state_next.tx_enable = 1'b1;
			state_next.tx_gate = cts_lvl;
		end else if (bus_config) begin
			state_next.tx_enable = 1'b1;
			state_next.tx_gate = 1'b0;
		end else begin
			state_next.tx_enable = ~cts_lvl;
			state_next.tx_gate = 1'b0;
		end

		// Shared carrier-detect pin functions per clock mode
		state_next.rx_gate = mode4 & cd_lvl;
		state_next.frame_sync = (clock_mode == modem_pins_pkg::CLK_MODE_5) & cd_lvl;
		state_next.rx_strobe = (clock_mode == modem_pins_pkg::CLK_MODE_1) & cd_lvl;
		state_next.modem_cd = ~mode4 && (clock_mode != modem_pins_pkg::CLK_MODE_5)
			&& (clock_mode != modem_pins_pkg::CLK_MODE_1) && cd_lvl;
		state_next.rx_enable = auto_start ? cd_lvl : 1'b1;

		// Level-change events, qualified by their enables
		cts_edge = state_next.cts_sync.filt ^ cts_lvl;
		cd_edge = state_next.cd_sync.filt ^ cd_lvl;
		state_next.cts_change = cts_edge & cts_event_en;
		state_next.cd_change = cd_edge & cd_event_en;

		// Clock source: crystal path feeds the oscillator modes
		state_next.use_crystal = ((clock_mode == modem_pins_pkg::CLK_MODE_0) & mode_b)
			| (clock_mode == modem_pins_pkg::CLK_MODE_6)
			| (clock_mode == modem_pins_pkg::CLK_MODE_7);
		state_next.crystal_level = state_reg.xtal_sync.filt;

		// APB: setup cycle prepares the answer, access phase completes in one cycle
		setup = psel & ~penable;
		access = psel & penable & state_reg.pready;
		hit_cfg = (paddr == modem_pins_pkg::CHANNEL_CONFIG_REG_ONE_OFS);
		hit_stat = (paddr == modem_pins_pkg::PIN_STATUS_OFS);
		wr = access & pwrite & ~state_reg.pslverr;
		state_next.pready = setup;
		state_next.pslverr = setup & ~(hit_cfg | hit_stat);
		if (setup && !pwrite) begin
			state_next.prdata = 32'h00000000;
			if (hit_cfg) begin
				state_next.prdata = state_reg.cfg;
			end else if (hit_stat) begin
				state_next.prdata[modem_pins_pkg::STAT_CTS_LEVEL_POS] = cts_lvl;
				state_next.prdata[modem_pins_pkg::STAT_CD_LEVEL_POS] = cd_lvl;
				state_next.prdata[modem_pins_pkg::STAT_COLLISION_POS +: 3] = state_reg.sticky;
				state_next.prdata[modem_pins_pkg::STAT_RTS_PIN_POS] = state_reg.rts_pin;
				state_next.prdata[modem_pins_pkg::STAT_TX_ENABLE_POS] = state_reg.tx_enable;
			end
		end else if (access) begin
			state_next.prdata = 32'h00000000;
		end
		if (wr && hit_cfg) begin
			state_next.cfg = pwdata & modem_pins_pkg::CFG_WRITE_MASK;
		end
		if (wr && hit_stat) begin
			clr_bits = pwdata[modem_pins_pkg::STAT_COLLISION_POS +: 3];
		end

		// Sticky flags: a new event wins over a same-cycle clear
		set_bits = {state_next.cd_change, state_next.cts_change, coll_now};
		state_next.sticky = (state_reg.sticky & ~clr_bits) | set_bits;
	end

	// ********************************************
	// State register
	// ********************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.cfg <= modem_pins_pkg::CFG_RESET;
			state_reg.sticky <= modem_pins_pkg::STAT_STICKY_RESET;
			state_reg.rts_state <= modem_pins_pkg::RTS_IDLE;
			state_reg.cts_sync <= modem_pins_pkg::CTS_SYNC_RESET;
			state_reg.rts_pin <= 1'b1; // Request inactive high
			state_reg.txd_out <= 1'b1;
			state_reg.txd_oe <= 1'b1;
			state_reg.rx_enable <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ********************************************
	// Outputs, all straight from the state register
	// ********************************************
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign rts_pin = state_reg.rts_pin;
	assign txd_out = state_reg.txd_out;
	assign txd_oe = state_reg.txd_oe;
	assign tx_enable = state_reg.tx_enable;
	assign rx_enable = state_reg.rx_enable;
	assign rx_strobe = state_reg.rx_strobe;
	assign frame_sync = state_reg.frame_sync;
	assign tx_clock_gate_input = state_reg.tx_gate;
	assign rx_clock_gate_input = state_reg.rx_gate;
	assign modem_cd_level = state_reg.modem_cd;
	assign collision_pulse = state_reg.collision;
	assign cts_change_pulse = state_reg.cts_change;
	assign cd_change_pulse = state_reg.cd_change;
	assign use_crystal = state_reg.use_crystal;
	assign crystal_clock_level = state_reg.crystal_level;
endmodule : serial_modem_control_pins

/* tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic tx_clock_pin, cts_pin, cd_pin, crystal_clock_input, rts_pin, txd_out, txd_oe;
	logic tx_data_in, tx_active, tx_pending, tx_collision_bit, rx_frame_active;
	logic shadow_empty, fifo_threshold, tx_enable, rx_enable, rx_strobe, frame_sync;
	logic tx_clock_gate_input, rx_clock_gate_input, modem_cd_level, collision_pulse;
	logic cts_change_pulse, cd_change_pulse, use_crystal, frame_on, cts_req, cd_req;
	logic bus_mode, bus_jam, rq, ta, th, crystal_clock_level;
	logic [1:0] am;
	logic [2:0] cm;
	int err_count, total_checks, cts_edges, cd_edges, hi, lo, xh;
	logic [64:0] exp_q[$];
	localparam logic [7:0] CFG = modem_pins_pkg::CHANNEL_CONFIG_REG_ONE_OFS;
	localparam logic [7:0] STAT = modem_pins_pkg::PIN_STATUS_OFS;
	localparam logic [31:0] ASY = 32'h1 << modem_pins_pkg::CFG_ASYNC_MODE_POS;
	localparam logic [31:0] BOD = (32'h1 << modem_pins_pkg::CFG_BUS_CONFIG_POS)
		| (32'h1 << modem_pins_pkg::CFG_OPEN_DRAIN_POS);

	serial_modem_control_pins serial_modem_control_pins_inst (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_clock_pin(tx_clock_pin),
		.cts_pin(cts_pin), .cd_pin(cd_pin), .crystal_clock_input(crystal_clock_input),
		.rts_pin(rts_pin), .txd_out(txd_out), .txd_oe(txd_oe), .tx_data_in(tx_data_in),
		.tx_active(tx_active), .tx_pending(tx_pending), .tx_collision_bit(tx_collision_bit),
		.rx_frame_active(rx_frame_active), .shadow_empty(shadow_empty),
		.fifo_threshold(fifo_threshold), .tx_enable(tx_enable), .rx_enable(rx_enable),
		.rx_strobe(rx_strobe), .frame_sync(frame_sync),
		.tx_clock_gate_input(tx_clock_gate_input), .rx_clock_gate_input(rx_clock_gate_input),
		.modem_cd_level(modem_cd_level), .collision_pulse(collision_pulse),
		.cts_change_pulse(cts_change_pulse), .cd_change_pulse(cd_change_pulse),
		.use_crystal(use_crystal), .crystal_clock_level(crystal_clock_level));

	modem_partner modem_partner_inst (.frame_on(frame_on), .cts_req(cts_req), .cd_req(cd_req),
		.bus_mode(bus_mode), .bus_jam(bus_jam), .txd_out(txd_out), .txd_oe(txd_oe),
		.tx_clock_pin(tx_clock_pin), .cts_pin(cts_pin),
		.crystal_clock_input(crystal_clock_input), .cd_pin(cd_pin));

	// ********
	// Clock, checking and bus tasks
	// ********
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task print_verdict();
		// A read note never answered is a lost comparison
		if (exp_q.size() != 0) err_count++;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// Request held until pready is seen high; a dead slave ends the run
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] e);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back(e);
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_count++;
			print_verdict();
		end
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 65'h0);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
		apb(1'b0, a, 32'h0, {er, m, e});
	endtask : rd

	// Watcher: oldest read note against what the slave answers, plus event counts
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			check({31'h0, pslverr}, {31'h0, exp_q[0][64]});
			check(prdata & exp_q[0][63:32], exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
		if (cts_change_pulse === 1'b1) cts_edges++;
		if (cd_change_pulse === 1'b1) cd_edges++;
	end

	// ********
	// Main sequence
	// ********
	initial begin
		{psel, penable, pwrite, paddr, pwdata, tx_data_in, tx_active, tx_pending} = '0;
		{tx_collision_bit, rx_frame_active, shadow_empty, fifo_threshold} = '0;
		{frame_on, cts_req, cd_req, bus_mode, bus_jam, err_count, total_checks} = '0;
		{cts_edges, cd_edges} = '0;
		rst = 1'b1;
		void'($urandom(44));
		cyc(8);
		rst <= 1'b0;
		cyc(3);
		check(tx_enable, 32'h0);
		cyc(3);
		rd(CFG, modem_pins_pkg::CFG_RESET, 32'hffffffff, 1'b0);
		rd(STAT, 32'h00000021, 32'hffffffe7, 1'b0);
		rd(8'h0c, 32'h0, 32'hffffffff, 1'b1);
		// Software request, then release waits for the transmitter
		tx_active <= 1'b1;
		wr(CFG, 32'h1 << modem_pins_pkg::CFG_RTS_REQUEST_POS);
		cyc(3);
		check(rts_pin, 32'h0);
		wr(CFG, 32'h0);
		cyc(3);
		check(rts_pin, 32'h0);
		tx_active <= 1'b0;
		tx_pending <= 1'b1;
		cyc(3);
		check(rts_pin, 32'h0);
		tx_pending <= 1'b0;
		cyc(3);
		check(rts_pin, 32'h1);
		// Clear-to-send gates the transmitter and raises one event
		wr(CFG, 32'h1 << modem_pins_pkg::CFG_CTS_EVENT_EN_POS);
		cts_req <= 1'b1;
		cyc(8);
		check(tx_enable, 32'h1);
		check(cts_edges, 32'h1);
		rd(STAT, 32'h00000048, 32'h00000049, 1'b0);
		cts_req <= 1'b0;
		cyc(8);
		check(tx_enable, 32'h0);
		// Asynchronous modes with random traffic; flow mode keeps shadow empty
		for (int i = 0; i < 12; i++) begin
			am = (i % 3 == 0) ? modem_pins_pkg::ASYNC_RTS_AUTO
				: (i % 3 == 1) ? modem_pins_pkg::ASYNC_RTS_FLOW : modem_pins_pkg::ASYNC_RTS_HOST;
			rq = 1'($urandom) & (am == modem_pins_pkg::ASYNC_RTS_HOST);
			ta = 1'($urandom);
			th = 1'($urandom);
			tx_active <= ta;
			shadow_empty <= 1'b1;
			fifo_threshold <= th;
			wr(CFG, ASY | (32'(am) << modem_pins_pkg::CFG_ASYNC_RTS_POS) | 32'(rq));
			cyc(3);
			check(rts_pin, (am == 2'h0) ? !ta : (am == 2'h1) ? th : !rq);
		end
		{tx_active, shadow_empty, fifo_threshold} <= 3'h0;
		// Bus configuration: receive option, disabled option, transmit option
		bus_mode <= 1'b1;
		rx_frame_active <= 1'b1;
		tx_data_in <= 1'b1;
		wr(CFG, BOD | (32'(modem_pins_pkg::BUS_RTS_ON_RX) << modem_pins_pkg::CFG_BUS_RTS_POS));
		cyc(4);
		check(rts_pin, 32'h0);
		check(txd_oe, 32'h0);
		rx_frame_active <= 1'b0;
		cyc(3);
		check(rts_pin, 32'h1);
		rx_frame_active <= 1'b1;
		tx_active <= 1'b1;
		wr(CFG, BOD | (32'h2 << modem_pins_pkg::CFG_BUS_RTS_POS));
		cyc(4);
		check(rts_pin, 32'h1);
		frame_on <= 1'b1;
		wr(CFG, BOD | (32'(modem_pins_pkg::BUS_RTS_ON_TX) << modem_pins_pkg::CFG_BUS_RTS_POS));
		cyc(30);
		check(rts_pin, 32'h0);
		tx_collision_bit <= 1'b1;
		cyc(30);
		check(rts_pin, 32'h1);
		tx_collision_bit <= 1'b0;
		tx_data_in <= 1'b0;
		cyc(3);
		check({txd_oe, txd_out}, 32'h2);
		// A jammed bus while sending a one is a collision
		tx_data_in <= 1'b1;
		bus_jam <= 1'b1;
		cyc(10);
		check(collision_pulse, 32'h1);
		bus_jam <= 1'b0;
		cyc(10);
		check(collision_pulse, 32'h0);
		rd(STAT, 32'h4, 32'h4, 1'b0);
		wr(STAT, 32'h1 << modem_pins_pkg::STAT_COLLISION_POS);
		rd(STAT, 32'h0, 32'h4, 1'b0);
		{frame_on, tx_active, bus_mode} <= 3'h0;
		// Every clock mode, carrier asserted; last pass is mode 0 without option b
		cd_req <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			cm = 3'(i);
			wr(CFG, (32'(cm) << modem_pins_pkg::CFG_CLOCK_MODE_POS)
				| (32'(i < 8) << modem_pins_pkg::CFG_MODE_B_POS));
			cyc(6);
			check(rx_strobe, 32'(cm == 3'h1));
			check(frame_sync, 32'(cm == 3'h5));
			check({tx_clock_gate_input, rx_clock_gate_input}, 32'(cm == 3'h4) * 3);
			check(modem_cd_level, 32'(cm inside {0, 2, 3, 6, 7}));
			check(use_crystal, 32'((cm == 3'h0 && i < 8) || cm >= 3'h6));
		end
		// Mode 4 with clock output: the pin must toggle with the link clock
		frame_on <= 1'b1;
		wr(CFG, (32'h4 << modem_pins_pkg::CFG_CLOCK_MODE_POS)
			| (32'h1 << modem_pins_pkg::CFG_TX_CLOCK_OUTPUT_ENABLE_POS));
		{hi, lo, xh} = '0;
		repeat (32) begin
			@(posedge ref_clk);
			if (rts_pin === 1'b1) hi++;
			else if (rts_pin === 1'b0) lo++;
			if (crystal_clock_level === 1'b1) xh++;
		end
		check(32'(hi >= 8 && lo >= 8), 32'h1);
		check(32'(xh >= 8 && xh <= 24), 32'h1);
		frame_on <= 1'b0;
		// Auto-start: carrier is the receiver enable; carrier events enabled
		wr(CFG, (32'h1 << modem_pins_pkg::CFG_AUTO_START_POS)
			| (32'h1 << modem_pins_pkg::CFG_CD_EVENT_EN_POS));
		cd_req <= 1'b0;
		cyc(8);
		check(rx_enable, 32'h0);
		cd_req <= 1'b1;
		cyc(8);
		check(rx_enable, 32'h1);
		check(cd_edges, 32'h2);
		print_verdict();
	end
endmodule : tb_top
